// ==== core/clk_pwr_pkg.sv ====
package clk_pwr_pkg;

   // register addresses
   localparam logic [31:0] ADDR_POWER_KEY_FIRST = 32'hFFFF0404;
   localparam logic [31:0] ADDR_POWER_MODE = 32'hFFFF0408;
   localparam logic [31:0] ADDR_POWER_KEY_SECOND = 32'hFFFF040C;
   localparam logic [31:0] ADDR_CLOCK_KEY_FIRST = 32'hFFFF0410;
   localparam logic [31:0] ADDR_CLOCK_SOURCE = 32'hFFFF0414;
   localparam logic [31:0] ADDR_CLOCK_KEY_SECOND = 32'hFFFF0418;

   // key values
   localparam logic [15:0] CLOCK_KEY_FIRST_VALUE = 16'h00AA;
   localparam logic [15:0] CLOCK_KEY_SECOND_VALUE = 16'h0055;
   localparam logic [15:0] POWER_KEY_FIRST_VALUE = 16'h0001;
   localparam logic [15:0] POWER_KEY_SECOND_VALUE = 16'h00F4;

   // unit index: 0 clock source, 1 power mode
   localparam int UNIT_CLOCK = 0;
   localparam int UNIT_POWER = 1;
   localparam logic [1:0][31:0] KEY_FIRST_ADDR = {ADDR_POWER_KEY_FIRST, ADDR_CLOCK_KEY_FIRST};
   localparam logic [1:0][31:0] CTRL_ADDR = {ADDR_POWER_MODE, ADDR_CLOCK_SOURCE};
   localparam logic [1:0][31:0] KEY_SECOND_ADDR = {ADDR_POWER_KEY_SECOND, ADDR_CLOCK_KEY_SECOND};
   localparam logic [1:0][15:0] KEY_FIRST_VALUE = {POWER_KEY_FIRST_VALUE, CLOCK_KEY_FIRST_VALUE};
   localparam logic [1:0][15:0] KEY_SECOND_VALUE =
      {POWER_KEY_SECOND_VALUE, CLOCK_KEY_SECOND_VALUE};

   // field encodings
   localparam logic [1:0] CLKMODE_PLL = 2'h1;
   localparam logic [1:0] CLKMODE_EXT_PIN = 2'h3;
   localparam logic [2:0] OPMODE_ACTIVE = 3'h0;
   localparam logic [2:0] OPMODE_PAUSE = 3'h1;
   localparam logic [2:0] OPMODE_NAP = 3'h2;
   localparam logic [2:0] OPMODE_SLEEP = 3'h3;
   localparam logic [2:0] OPMODE_STOP = 3'h4;

   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int WAKE_TIMER_MIN_NS = 120000;
   localparam int WAKE_TIMER_MIN_CYCLES = (WAKE_TIMER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] SETTLE_COUNT = 12'(WAKE_TIMER_MIN_CYCLES);
   localparam logic [10:0] PLL_MULT = 11'h4FB;
   localparam logic [10:0] LOCK_TOL = 11'h002;
   localparam logic [10:0] REF_COUNT_MAX = 11'h7FF;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_KEYED = 3'b010,
      SEQ_STAGED = 3'b100
   } key_seq_t;

   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic ref_sel;
      logic [2:0] rsvd_mid;
      logic [1:0] mode;
   } clock_source_t;

   typedef struct packed {
      logic rsvd_hi;
      logic [2:0] opmode;
      logic rsvd_mid;
      logic [2:0] cd;
   } power_mode_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // reset values
   localparam clock_source_t CLOCK_SOURCE_RESET = 8'h21;
   localparam power_mode_t POWER_MODE_RESET = 8'h03;
endpackage

// ==== core/clock_power_mode_control.sv ====
`timescale 1ns/1ps
module clock_power_mode_control
   import clk_pwr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire reg_req_t bus_req,
   output logic [15:0] rdata,
   // reference, wake and interrupt handshake
   input wire logic ref_tick,
   input wire logic [3:0] external_interrupt,
   input wire logic wakeup_timer_irq,
   input wire logic pll_irq_ack,
   // clock system controls
   output logic reference_select,
   output logic [1:0] clocking_mode_field,
   output logic [2:0] operating_mode_field,
   output logic [2:0] core_clock_divider,
   output logic core_clk_en,
   output logic pll_locked,
   output logic pll_irq
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   clock_source_t clock_source_control;
   power_mode_t power_mode_control;
   key_seq_t seq_state [2];
   logic [7:0] staged [2];
   logic [1:0] commit;
   clock_source_t clk_new;
   power_mode_t pow_new;
   logic wake_event;
   logic switch_now;
   logic [11:0] nap_cycles;
   logic [6:0] div_count;
   logic [6:0] div_mask;
   logic [10:0] ref_count;
   logic next_locked;
   logic irq_pending;
   logic next_pending;

   // key sequencers
   always_comb begin
      for (int u = 0; u < 2; u++) begin
         commit[u] = bus_req.wr && seq_state[u] == SEQ_STAGED
            && bus_req.addr == KEY_SECOND_ADDR[u]
            && bus_req.wdata == KEY_SECOND_VALUE[u];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int u = 0; u < 2; u++) begin
            seq_state[u] <= SEQ_IDLE;
            staged[u] <= 8'h00;
         end
      end else if (bus_req.wr) begin
         for (int u = 0; u < 2; u++) begin
            case (seq_state[u])
               SEQ_KEYED: begin
                  if (bus_req.addr == CTRL_ADDR[u]) begin
                     seq_state[u] <= SEQ_STAGED;
                     staged[u] <= bus_req.wdata[7:0];
                  end else if (bus_req.addr == KEY_FIRST_ADDR[u]
                     && bus_req.wdata == KEY_FIRST_VALUE[u]) begin
                     seq_state[u] <= SEQ_KEYED;
                  end else begin
                     seq_state[u] <= SEQ_IDLE;
                  end
               end
               default: begin
                  if (bus_req.addr == KEY_FIRST_ADDR[u]
                     && bus_req.wdata == KEY_FIRST_VALUE[u]) begin
                     seq_state[u] <= SEQ_KEYED;
                  end else begin
                     seq_state[u] <= SEQ_IDLE;
                  end
               end
            endcase
         end
      end
   end

   unkeyed_write_a: assert property (
      bus_req.wr && bus_req.addr == ADDR_CLOCK_SOURCE && seq_state[UNIT_CLOCK] != SEQ_KEYED
      |=> seq_state[UNIT_CLOCK] == SEQ_IDLE ##1 $stable(clock_source_control))
      else $error("unkeyed clock source write was not dropped");

   // clock source register
   assign clk_new = clock_source_t'(staged[UNIT_CLOCK]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_source_control <= CLOCK_SOURCE_RESET;
      end else if (commit[UNIT_CLOCK]) begin
         clock_source_control.ref_sel <= clk_new.ref_sel;
         if (clk_new.mode == CLKMODE_PLL || clk_new.mode == CLKMODE_EXT_PIN) begin
            clock_source_control.mode <= clk_new.mode;
         end
      end
   end

   clock_reg_guard_a: assert property (
      $changed(clock_source_control) |-> $past(commit[UNIT_CLOCK]))
      else $error("clock source changed without key sequence");

   clock_commit_a: assert property (
      commit[UNIT_CLOCK] && clk_new.mode == CLKMODE_EXT_PIN
      |=> clock_source_control.mode == CLKMODE_EXT_PIN)
      else $error("keyed clock source value not applied");

   // power mode register and wake-up
   assign pow_new = power_mode_t'(staged[UNIT_POWER]);
   assign wake_event = power_mode_control.opmode != OPMODE_ACTIVE
      && ((|external_interrupt)
      || (wakeup_timer_irq && power_mode_control.opmode != OPMODE_STOP));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_control <= POWER_MODE_RESET;
      end else if (commit[UNIT_POWER]) begin
         power_mode_control.cd <= pow_new.cd;
         if (pow_new.opmode <= OPMODE_STOP) begin
            power_mode_control.opmode <= pow_new.opmode;
         end
      end else if (wake_event) begin
         power_mode_control.opmode <= OPMODE_ACTIVE;
      end
   end

   assign operating_mode_field = power_mode_control.opmode;
   assign core_clock_divider = power_mode_control.cd;

   power_reg_guard_a: assert property (
      $changed(power_mode_control) |-> $past(commit[UNIT_POWER]) || $past(wake_event))
      else $error("power mode changed without key sequence or wake");

   sleep_wake_a: assert property (
      power_mode_control.opmode == OPMODE_SLEEP && (|external_interrupt)
      && !commit[UNIT_POWER] |=> operating_mode_field == OPMODE_ACTIVE)
      else $error("sleep not left on external interrupt");

   stop_hold_a: assert property (
      power_mode_control.opmode == OPMODE_STOP && !(|external_interrupt)
      && !commit[UNIT_POWER] |=> operating_mode_field == OPMODE_STOP)
      else $error("stop left without external interrupt");

   // nap residency and source switch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nap_cycles <= 12'h000;
      end else if (power_mode_control.opmode != OPMODE_NAP) begin
         nap_cycles <= 12'h000;
      end else if (nap_cycles < SETTLE_COUNT) begin
         nap_cycles <= nap_cycles + 12'h001;
      end
   end

   assign switch_now = power_mode_control.opmode == OPMODE_NAP && wakeup_timer_irq
      && nap_cycles >= SETTLE_COUNT;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reference_select <= CLOCK_SOURCE_RESET.ref_sel;
         clocking_mode_field <= CLOCK_SOURCE_RESET.mode;
      end else if (switch_now) begin
         reference_select <= clock_source_control.ref_sel;
         clocking_mode_field <= clock_source_control.mode;
      end
   end

   ref_select_apply_a: assert property (
      switch_now && !commit[UNIT_CLOCK]
      |=> reference_select == clock_source_control.ref_sel)
      else $error("reference select not taken at nap wake");

   clock_mode_legal_a: assert property (
      clocking_mode_field == CLKMODE_PLL || clocking_mode_field == CLKMODE_EXT_PIN)
      else $error("clocking mode holds a reserved code");

   settle_guard_a: assert property (
      $changed(clocking_mode_field) || $changed(reference_select)
      |-> $past(nap_cycles) >= SETTLE_COUNT)
      else $error("clock source switched before settle time");

   // pll lock monitor
   always_comb begin
      next_locked = pll_locked;
      if (ref_tick) begin
         next_locked = ref_count >= PLL_MULT - 11'h001 - LOCK_TOL
            && ref_count <= PLL_MULT - 11'h001 + LOCK_TOL;
      end else if (ref_count > PLL_MULT - 11'h001 + LOCK_TOL) begin
         next_locked = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_count <= 11'h000;
      end else if (ref_tick) begin
         ref_count <= 11'h000;
      end else if (ref_count != REF_COUNT_MAX) begin
         ref_count <= ref_count + 11'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_locked <= 1'b0;
      end else begin
         pll_locked <= next_locked;
      end
   end

   lock_period_a: assert property (
      ref_tick && ref_count < PLL_MULT - 11'h001 - LOCK_TOL |=> !pll_locked)
      else $error("lock kept with short reference period");

   lock_overrun_a: assert property (
      !ref_tick && ref_count > PLL_MULT - 11'h001 + LOCK_TOL |=> !pll_locked)
      else $error("lock kept with long reference period");

   // pll interrupt held back until relock
   always_comb begin
      next_pending = irq_pending;
      if (pll_locked && !next_locked) begin
         next_pending = 1'b1;
      end else if (pll_irq_ack) begin
         next_pending = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending <= 1'b0;
         pll_irq <= 1'b0;
      end else begin
         irq_pending <= next_pending;
         pll_irq <= next_pending && next_locked;
      end
   end

   pll_irq_gate_a: assert property (
      pll_irq |-> pll_locked)
      else $error("pll interrupt raised while unlocked");

   lock_loss_irq_a: assert property (
      $fell(pll_locked) |-> irq_pending)
      else $error("lock loss not recorded");

   // core clock divider
   assign div_mask = 7'((8'h01 << power_mode_control.cd) - 8'h01);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_count <= 7'h00;
      end else begin
         div_count <= div_count + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_clk_en <= 1'b0;
      end else begin
         core_clk_en <= next_locked && power_mode_control.opmode == OPMODE_ACTIVE
            && (div_count & div_mask) == div_mask;
      end
   end

   core_halt_a: assert property (
      core_clk_en |-> pll_locked)
      else $error("core clock ran while pll unlocked");

   divider_pace_a: assert property (
      core_clk_en && core_clock_divider == 3'h1 && $stable(core_clock_divider) |=> !core_clk_en)
      else $error("core clock enable too fast for divider");

   // register read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (bus_req.rd) begin
         if (bus_req.addr == ADDR_CLOCK_SOURCE) begin
            rdata <= {8'h00, clock_source_control};
         end else if (bus_req.addr == ADDR_POWER_MODE) begin
            rdata <= {8'h00, power_mode_control};
         end else begin
            rdata <= 16'h0000;
         end
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule // clock_power_mode_control

// ==== bench/clock_power_mode_control_tb.sv ====
`timescale 1ns/1ps
module clock_power_mode_control_tb;
   import clk_pwr_pkg::*;
   logic clk;
   logic rst_n;
   reg_req_t bus_req;
   logic [15:0] rdata;
   logic ref_tick;
   logic [3:0] external_interrupt;
   logic wakeup_timer_irq;
   logic pll_irq_ack;
   logic reference_select;
   logic [1:0] clocking_mode_field;
   logic [2:0] operating_mode_field;
   logic [2:0] core_clock_divider;
   logic core_clk_en;
   logic pll_locked;
   logic pll_irq;
   int failures = 0;
   int n_checks = 0;
   int tick_cnt = 0;
   bit tick_on = 1'b0;
   bit tick_early = 1'b0;
   int hits;
   int d;

   clock_power_mode_control clock_power_mode_control_inst (
      .clk(clk),
      .rst_n(rst_n),
      .bus_req(bus_req),
      .rdata(rdata),
      .ref_tick(ref_tick),
      .external_interrupt(external_interrupt),
      .wakeup_timer_irq(wakeup_timer_irq),
      .pll_irq_ack(pll_irq_ack),
      .reference_select(reference_select),
      .clocking_mode_field(clocking_mode_field),
      .operating_mode_field(operating_mode_field),
      .core_clock_divider(core_clock_divider),
      .core_clk_en(core_clk_en),
      .pll_locked(pll_locked),
      .pll_irq(pll_irq)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // reference tick at the nominal multiplier spacing, or every 600 cycles when tick_early is set
   always @(posedge clk) begin
      tick_cnt = tick_cnt + 1;
      if ((tick_on && tick_cnt >= int'(PLL_MULT)) || (tick_early && tick_cnt >= 600)) begin
         ref_tick <= 1'b1;
         tick_cnt = 0;
      end else begin
         ref_tick <= 1'b0;
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] w);
      @(posedge clk);
      bus_req <= {a, w, 1'b1, 1'b0};
   endtask

   task automatic idle();
      @(posedge clk);
      bus_req <= '0;
      #1;
   endtask

   task automatic rd(input logic [31:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus_req <= {a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      bus_req <= '0;
      #1;
      chk("rdata", exp, rdata);
   endtask

   task automatic key(input int u, input logic [15:0] w);
      wr(KEY_FIRST_ADDR[u], KEY_FIRST_VALUE[u]);
      wr(CTRL_ADDR[u], w);
      wr(KEY_SECOND_ADDR[u], KEY_SECOND_VALUE[u]);
      idle();
   endtask

   task automatic pulse(input logic [3:0] e, input logic t);
      @(posedge clk);
      external_interrupt <= e;
      wakeup_timer_irq <= t;
      @(posedge clk);
      external_interrupt <= 4'h0;
      wakeup_timer_irq <= 1'b0;
      #1;
   endtask

   task automatic count_en(input int n);
      hits = 0;
      repeat (n) begin
         step(1);
         if (core_clk_en === 1'b1) begin
            hits++;
         end
      end
   endtask

   task automatic wait_lock(input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim && pll_locked !== lvl; i++) begin
         step(1);
      end
      if (pll_locked !== lvl) begin
         $display("CHECK FAILED pll_locked expected %b seen %b", lvl, pll_locked);
         failures++;
         close_out();
      end
   endtask

   initial begin
      rst_n = 1'b0;
      bus_req = '0;
      external_interrupt = 4'h0;
      wakeup_timer_irq = 1'b0;
      pll_irq_ack = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      step(1);
      chk("ref_sel", 16'h0001, 16'(reference_select));
      chk("clk_mode", 16'(CLKMODE_PLL), 16'(clocking_mode_field));
      chk("divider", 16'h0003, 16'(core_clock_divider));
      chk("opmode", 16'(OPMODE_ACTIVE), 16'(operating_mode_field));
      rd(ADDR_CLOCK_SOURCE, 16'h0021);
      rd(ADDR_POWER_MODE, 16'h0003);
      rd(ADDR_CLOCK_KEY_FIRST, 16'h0000);
      rd(32'hFFFF0400, 16'h0000);
      // unkeyed, interrupted and wrong-key writes
      wr(ADDR_CLOCK_SOURCE, 16'h0003);
      wr(ADDR_CLOCK_KEY_FIRST, CLOCK_KEY_FIRST_VALUE);
      wr(ADDR_POWER_KEY_FIRST, POWER_KEY_FIRST_VALUE);
      wr(ADDR_CLOCK_SOURCE, 16'h0003);
      wr(ADDR_CLOCK_KEY_SECOND, CLOCK_KEY_SECOND_VALUE);
      wr(ADDR_CLOCK_KEY_FIRST, CLOCK_KEY_FIRST_VALUE);
      wr(ADDR_CLOCK_SOURCE, 16'h0003);
      wr(ADDR_CLOCK_KEY_SECOND, 16'h0056);
      rd(ADDR_CLOCK_SOURCE, 16'h0021);
      key(UNIT_CLOCK, 16'h0003);
      rd(ADDR_CLOCK_SOURCE, 16'h0003);
      chk("ref_sel", 16'h0001, 16'(reference_select));
      chk("clk_mode", 16'(CLKMODE_PLL), 16'(clocking_mode_field));
      key(UNIT_CLOCK, 16'h0002);
      rd(ADDR_CLOCK_SOURCE, 16'h0003);
      key(UNIT_POWER, 16'h00DD);
      rd(ADDR_POWER_MODE, 16'h0005);
      chk("divider", 16'h0005, 16'(core_clock_divider));
      // lock, then every divider code
      tick_on = 1'b1;
      wait_lock(1'b1, 4000);
      for (d = 0; d < 8; d++) begin
         key(UNIT_POWER, 16'(d));
         count_en(256);
         chk("clk_en_count", 16'(256 >> d), 16'(hits));
      end
      // each low-power mode, woken by one interrupt line
      for (d = 1; d < 5; d++) begin
         key(UNIT_POWER, 16'(d << 4));
         chk("opmode", 16'(d), 16'(operating_mode_field));
         count_en(8);
         chk("clk_en_count", 16'h0000, 16'(hits));
         if (d == 4) begin
            pulse(4'h0, 1'b1);
            chk("opmode", 16'(OPMODE_STOP), 16'(operating_mode_field));
         end
         pulse(4'(1 << (d - 1)), 1'b0);
         chk("opmode", 16'(OPMODE_ACTIVE), 16'(operating_mode_field));
      end
      // early timer wake from nap keeps the old source
      key(UNIT_POWER, {9'h000, OPMODE_NAP, 4'h0});
      pulse(4'h0, 1'b1);
      chk("opmode", 16'(OPMODE_ACTIVE), 16'(operating_mode_field));
      chk("ref_sel", 16'h0001, 16'(reference_select));
      key(UNIT_POWER, {9'h000, OPMODE_NAP, 4'h0});
      step(int'(SETTLE_COUNT) + 10);
      pulse(4'h0, 1'b1);
      chk("ref_sel", 16'h0000, 16'(reference_select));
      chk("clk_mode", 16'(CLKMODE_EXT_PIN), 16'(clocking_mode_field));
      chk("opmode", 16'(OPMODE_ACTIVE), 16'(operating_mode_field));
      // reference stops: lock loss and deferred interrupt
      tick_on = 1'b0;
      wait_lock(1'b0, 1400);
      chk("clk_en", 16'h0000, 16'(core_clk_en));
      chk("pll_irq", 16'h0000, 16'(pll_irq));
      tick_on = 1'b1;
      wait_lock(1'b1, 4000);
      step(2);
      chk("pll_irq", 16'h0001, 16'(pll_irq));
      @(posedge clk);
      pll_irq_ack <= 1'b1;
      @(posedge clk);
      pll_irq_ack <= 1'b0;
      step(1);
      chk("pll_irq", 16'h0000, 16'(pll_irq));
      // short reference period drops the lock
      tick_early = 1'b1;
      wait_lock(1'b0, 1400);
      chk("clk_en", 16'h0000, 16'(core_clk_en));
      chk("pll_irq", 16'h0000, 16'(pll_irq));
      close_out();
   end
endmodule // clock_power_mode_control_tb
